// file: design/vrc_pkg.sv
// Package for the video memory random-port controller: timing, encodings, pin widths.
package vrc_pkg;

	// ****************************************
	// Array geometry
	// ****************************************
	localparam int ADDR_W = 9;
	localparam int DATA_W = 4;
	localparam int ROWS = 512;

	// ****************************************
	// Timing at 100 MHz
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int REFRESH_PERIOD_MS = 8;
	// Longest time per row: round down
	localparam int REFRESH_PERIOD_CYC = (REFRESH_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
	localparam int REFRESH_ROW_CYC = REFRESH_PERIOD_CYC / ROWS;
	localparam int PHASE_CYC = 2;
	localparam logic [3:0] PHASE_LAST = 4'h1;

	// ****************************************
	// Commands
	// ****************************************
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_MASKED_WRITE = 2'h2;
	localparam logic [1:0] CMD_RMW = 2'h3;

	typedef enum logic [3:0] {
		VRC_IDLE,
		VRC_ROW,
		VRC_RAS,
		VRC_COL,
		VRC_CAS,
		VRC_WE,
		VRC_PRE,
		VRC_CBR_CAS,
		VRC_CBR_RAS
	} vrc_state_t;

endpackage : vrc_pkg

// file: design/vrc_ctrl.sv
// Controller that drives the random port of the dual-ported video memory.
// Function
// [RULE1] Hold transfer select high at row strobe fall for random access.
// [RULE2] Transfer select low at row strobe fall would start a transfer; never done.
// [RULE3] Device floats data while transfer select high; it doubles as output enable.
// [RULE4] Device latches row on row strobe fall, column on column strobe fall.
// [RULE5] Address stays stable before and across each strobe fall.
// [RULE6] Write, transfer, serial and column strobe levels at row fall pick function.
// [RULE7] Column strobe also enables the device's data outputs.
// [RULE8] Write enable high reads, low writes.
// [RULE9] Write enable low at row strobe fall turns on masked write.
// [RULE10] Mask on data pins at row fall; ones are written, zeros kept.
// [RULE11] Write data latched on later fall of column strobe or write enable.
// [RULE12] Early write: write enable before column strobe, outputs stay floated.
// [RULE13] Delayed write or read-modify-write: data strobed by write enable fall.
// [RULE14] Read data valid only while column strobe and transfer select low.
// [RULE15] Read data has the polarity it was written with.
// [RULE16] Outputs float through any transfer cycle.
// [RULE17] Column latches transparent while column strobe high, frozen at its fall.
// [RULE18] Page mode: many column accesses within one row strobe low period.
// [RULE19] Every row refreshed at least once per eight milliseconds.
// [RULE20] Row-strobe-only refresh leaves column strobe high, steps all rows; not used, every refresh here is column before row.
// [RULE21] Column before row strobe refreshes from the internal row counter.
// [RULE22] Internal refresh counter advances after each such refresh.
module vrc_ctrl #(
	parameter int REFRESH_ROW_CYCLES = vrc_pkg::REFRESH_ROW_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_cmd,
	input wire logic [vrc_pkg::ADDR_W-1:0] req_row,
	input wire logic [vrc_pkg::ADDR_W-1:0] req_col,
	input wire logic req_last,
	input wire logic [vrc_pkg::DATA_W-1:0] req_wdata,
	input wire logic [vrc_pkg::DATA_W-1:0] req_mask,
	output logic rd_valid,
	output logic [vrc_pkg::DATA_W-1:0] rd_data,
	output logic row_strobe_n,
	output logic column_strobe_n,
	output logic write_enable_n,
	output logic transfer_select_n,
	output logic serial_mode_select_n,
	output logic [vrc_pkg::ADDR_W-1:0] multiplexed_address,
	output logic [vrc_pkg::DATA_W-1:0] random_data_pins_o,
	output logic random_data_pins_oe,
	input wire logic [vrc_pkg::DATA_W-1:0] random_data_pins_i
);
	import vrc_pkg::*;

	// ****************************************
	// Reset and pin synchronisers
	// ****************************************
	logic rst_s1_r, rst_s2_r;
	logic [DATA_W-1:0] dq_s1_r, dq_s2_r;

	// Reset release through two stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	wire srst_n = rst_s2_r;

	// Data pins come from outside the clock domain
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			dq_s1_r <= '0;
			dq_s2_r <= '0;
		end else begin
			dq_s1_r <= random_data_pins_i;
			dq_s2_r <= dq_s1_r;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	vrc_state_t st_r, st_nxt;
	logic [3:0] ph_r, ph_nxt;
	logic [31:0] ref_cnt_r, ref_cnt_nxt;
	logic ref_due_r, ref_due_nxt;
	logic [1:0] cmd_r, cmd_nxt;
	logic [ADDR_W-1:0] row_r, row_nxt, col_r, col_nxt;
	logic [DATA_W-1:0] wd_r, wd_nxt, mask_r, mask_nxt;
	logic last_r, last_nxt;
	logic ras_r, ras_nxt, cas_r, cas_nxt, we_r, we_nxt, trg_r, trg_nxt;
	logic [ADDR_W-1:0] a_r, a_nxt;
	logic [DATA_W-1:0] dqo_r, dqo_nxt;
	logic oe_r, oe_nxt, rdv_r, rdv_nxt;
	logic [DATA_W-1:0] rdd_r, rdd_nxt;
	logic smp_r, smp_nxt;
	logic take;

	function automatic logic is_write(input logic [1:0] c);
		return c == CMD_WRITE || c == CMD_MASKED_WRITE;
	endfunction : is_write

	// Nothing is taken in reset; a page only takes same-row, unmasked work, and yields to refresh
	assign req_ready = srst_n && ((st_r == VRC_IDLE && !ref_due_r) ||
		(st_r == VRC_PRE && !last_r && !ref_due_r && req_row == row_r &&
		req_cmd != CMD_MASKED_WRITE)); // RULE9 RULE19
	assign take = req_valid && req_ready;
	wire ph_done = ph_r == PHASE_LAST;

	// Next-state, pin and refresh-timer logic
	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_done ? 4'h0 : ph_r + 4'h1;
		ref_cnt_nxt = ref_cnt_r + 32'h1;
		ref_due_nxt = ref_due_r;
		cmd_nxt = cmd_r;
		row_nxt = row_r;
		col_nxt = col_r;
		wd_nxt = wd_r;
		mask_nxt = mask_r;
		last_nxt = last_r;
		ras_nxt = ras_r;
		cas_nxt = cas_r;
		we_nxt = we_r;
		trg_nxt = 1'b1; // RULE1 RULE16
		a_nxt = a_r;
		dqo_nxt = dqo_r;
		oe_nxt = oe_r;
		rdv_nxt = 1'b0;
		rdd_nxt = rdd_r;
		smp_nxt = smp_r;
		// Refresh per row paced so all rows fit in the period
		if (ref_cnt_r >= 32'(REFRESH_ROW_CYCLES - 1)) begin
			ref_cnt_nxt = 32'h0;
			ref_due_nxt = 1'b1; // RULE19 RULE20
		end
		unique case (st_r)
			VRC_IDLE: begin
				ph_nxt = 4'h0;
				if (ref_due_r) begin
					// Column first selects the internal refresh row
					cas_nxt = 1'b0; // RULE21 RULE22
					oe_nxt = 1'b0;
					st_nxt = VRC_CBR_CAS;
				end else if (take) begin
					cmd_nxt = req_cmd;
					row_nxt = req_row;
					col_nxt = req_col;
					wd_nxt = req_wdata;
					mask_nxt = req_mask;
					last_nxt = req_last;
					a_nxt = req_row; // RULE5
					// Masked write: write enable and mask set before row fall
					we_nxt = req_cmd != CMD_MASKED_WRITE; // RULE9 RULE6
					dqo_nxt = req_mask; // RULE10
					oe_nxt = req_cmd == CMD_MASKED_WRITE;
					st_nxt = VRC_ROW;
				end
			end
			VRC_ROW: if (ph_done) begin
				ras_nxt = 1'b0; // RULE4
				st_nxt = VRC_RAS;
			end
			VRC_RAS: if (ph_done) begin
				// Column put out while the latch is still transparent
				a_nxt = col_r; // RULE17 RULE5
				oe_nxt = is_write(cmd_r);
				dqo_nxt = wd_r;
				we_nxt = !is_write(cmd_r); // RULE8 RULE12
				trg_nxt = is_write(cmd_r); // RULE3 RULE14
				st_nxt = VRC_COL;
			end
			VRC_COL: begin
				trg_nxt = is_write(cmd_r);
				if (ph_done) begin
					cas_nxt = 1'b0; // RULE4 RULE11 RULE7
					st_nxt = VRC_CAS;
				end
			end
			VRC_CAS: begin
				trg_nxt = is_write(cmd_r);
				if (ph_done && !is_write(cmd_r) && !smp_r) begin
					// Extra phase: read data must cross both sync stages first
					smp_nxt = 1'b1;
				end else if (ph_done) begin
					smp_nxt = 1'b0;
					if (!is_write(cmd_r)) begin
						rdv_nxt = cmd_r == CMD_READ;
						rdd_nxt = dq_s2_r; // RULE15
					end
					if (cmd_r == CMD_RMW) begin
						// Outputs released in the same cycle as the modified data is driven
						trg_nxt = 1'b1;
						oe_nxt = 1'b1;
						dqo_nxt = wd_r;
						st_nxt = VRC_WE;
					end else begin
						cas_nxt = 1'b1;
						we_nxt = 1'b1;
						oe_nxt = 1'b0;
						st_nxt = VRC_PRE;
					end
				end
			end
			VRC_WE: if (ph_done) begin
				if (we_r == 1'b1) begin
					we_nxt = 1'b0; // RULE13
				end else begin
					cas_nxt = 1'b1;
					we_nxt = 1'b1;
					oe_nxt = 1'b0;
					st_nxt = VRC_PRE;
				end
			end
			VRC_PRE: begin
				if (!last_r && take && req_row == row_r) begin
					// Same row: stay open for another column
					cmd_nxt = req_cmd; // RULE18
					col_nxt = req_col;
					wd_nxt = req_wdata;
					last_nxt = req_last;
					ph_nxt = 4'h0;
					st_nxt = VRC_RAS;
				end else if (ph_done) begin
					ras_nxt = 1'b1;
					oe_nxt = 1'b0;
					st_nxt = VRC_IDLE;
				end
			end
			VRC_CBR_CAS: if (ph_done) begin
				ras_nxt = 1'b0;
				ref_due_nxt = 1'b0;
				st_nxt = VRC_CBR_RAS;
			end
			VRC_CBR_RAS: if (ph_done) begin
				ras_nxt = 1'b1;
				cas_nxt = 1'b1;
				st_nxt = VRC_IDLE;
			end
			default: st_nxt = VRC_IDLE;
		endcase
		// Timer tick wins over the clear in the same cycle
		if (st_r == VRC_CBR_CAS && ph_done && ref_cnt_r >= 32'(REFRESH_ROW_CYCLES - 1)) begin
			ref_due_nxt = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge srst_n) begin
		if (!srst_n) begin
			st_r <= VRC_IDLE;
			ph_r <= 4'h0;
			ref_cnt_r <= 32'h0;
			ref_due_r <= 1'b0;
			cmd_r <= CMD_READ;
			row_r <= '0;
			col_r <= '0;
			wd_r <= '0;
			mask_r <= '0;
			last_r <= 1'b1;
			ras_r <= 1'b1;
			cas_r <= 1'b1;
			we_r <= 1'b1;
			trg_r <= 1'b1;
			a_r <= '0;
			dqo_r <= '0;
			oe_r <= 1'b0;
			rdv_r <= 1'b0;
			rdd_r <= '0;
			smp_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			ref_cnt_r <= ref_cnt_nxt;
			ref_due_r <= ref_due_nxt;
			cmd_r <= cmd_nxt;
			row_r <= row_nxt;
			col_r <= col_nxt;
			wd_r <= wd_nxt;
			mask_r <= mask_nxt;
			last_r <= last_nxt;
			ras_r <= ras_nxt;
			cas_r <= cas_nxt;
			we_r <= we_nxt;
			trg_r <= trg_nxt;
			a_r <= a_nxt;
			dqo_r <= dqo_nxt;
			oe_r <= oe_nxt;
			rdv_r <= rdv_nxt;
			rdd_r <= rdd_nxt;
			smp_r <= smp_nxt;
		end
	end

	// Pins straight from flip-flops, except serial mode select tied high
	assign row_strobe_n = ras_r;
	assign column_strobe_n = cas_r;
	assign write_enable_n = we_r;
	assign transfer_select_n = trg_r;
	assign serial_mode_select_n = 1'b1;
	assign multiplexed_address = a_r;
	assign random_data_pins_o = dqo_r;
	assign random_data_pins_oe = oe_r;
	assign rd_valid = rdv_r;
	assign rd_data = rdd_r;

	// ****************************************
	// Checks
	// ****************************************
	trg_at_ras_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE1
		$fell(row_strobe_n) |-> transfer_select_n)
		else $error("transfer select low at row strobe fall");
	no_contention_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE3
		!transfer_select_n |-> !random_data_pins_oe)
		else $error("controller drives data while outputs enabled");
	mask_at_ras_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE10
		($fell(row_strobe_n) && !write_enable_n) |-> random_data_pins_oe)
		else $error("no mask on pins at masked row fall");
	addr_stable_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE5
		$fell(column_strobe_n) && !row_strobe_n |-> $stable(multiplexed_address))
		else $error("address moved at column strobe fall");
	early_write_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE12
		($fell(column_strobe_n) && !write_enable_n && !row_strobe_n) |-> transfer_select_n)
		else $error("early write with outputs enabled");
	wdata_driven_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE11
		($fell(column_strobe_n) && !write_enable_n) |-> random_data_pins_oe)
		else $error("write strobe without data driven");
	rmw_strobe_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE13
		($fell(write_enable_n) && !column_strobe_n) |-> random_data_pins_oe && transfer_select_n)
		else $error("delayed write strobe without data");
	cbr_hold_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE21
		$fell(column_strobe_n) && row_strobe_n |-> ##2 !row_strobe_n)
		else $error("refresh row strobe not following column strobe");
	refresh_bound_a: assert property (@(posedge clk) disable iff (!srst_n) // RULE19
		ref_cnt_r < 32'(REFRESH_ROW_CYCLES))
		else $error("refresh timer overran");

endmodule : vrc_ctrl

// file: dv/vrc_mem_model.sv
// Behavioural model of the video memory random port, driven by strobe edges.
module vrc_mem_model (
	input wire logic clk,
	input wire logic row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_enable_n,
	input wire logic transfer_select_n,
	input wire logic [vrc_pkg::ADDR_W-1:0] multiplexed_address,
	input wire logic random_data_pins_oe,
	input wire logic [vrc_pkg::DATA_W-1:0] dq,
	output logic [vrc_pkg::DATA_W-1:0] dq_out,
	output int faults = 0,
	output int refreshes = 0,
	output int max_gap = 0
);
	import vrc_pkg::*;
	logic [DATA_W-1:0] mem [0:(1<<(2*ADDR_W))-1];
	logic [ADDR_W-1:0] row_r, col_r;
	logic [ADDR_W-1:0] ref_row = '0;
	logic [DATA_W-1:0] mask_r;
	logic [DATA_W-1:0] last_r = '0;
	logic rnd = 0;
	logic early = 0;
	logic drive;
	int gap = 0;
	int seen = 0;

	function automatic logic [DATA_W-1:0] wr(logic [DATA_W-1:0] old);
		return (old & ~mask_r) | (dq & mask_r);
	endfunction : wr

	// Row strobe fall picks the cycle function
	always @(negedge row_strobe_n) begin
		rnd = column_strobe_n && transfer_select_n;
		if (!column_strobe_n) begin
			ref_row = ref_row + 1'b1;
			refreshes++;
		end
		if (column_strobe_n && !transfer_select_n)
			faults++;
		row_r = multiplexed_address;
		mask_r = write_enable_n ? '1 : dq;
	end

	// Column latch freezes at each fall, so a page may repeat it
	always @(negedge column_strobe_n) begin
		col_r = multiplexed_address;
		early = !write_enable_n;
		if (rnd && !row_strobe_n && early)
			mem[{row_r, col_r}] = wr(mem[{row_r, col_r}]);
	end

	// Late write enable strobes the data
	always @(negedge write_enable_n) begin
		if (rnd && !row_strobe_n && !column_strobe_n)
			mem[{row_r, col_r}] = wr(mem[{row_r, col_r}]);
	end

	// Drive only in a read with both enables low; released pins show a wrong value
	assign drive = rnd && !row_strobe_n && !column_strobe_n && !transfer_select_n && !early;
	assign dq_out = drive ? mem[{row_r, col_r}] : ~last_r;

	// Contention and refresh spacing watch
	always @(posedge clk) begin
		if (drive)
			last_r <= mem[{row_r, col_r}];
		if (drive && random_data_pins_oe)
			faults++;
		gap <= (refreshes != seen) ? 0 : gap + 1;
		seen <= refreshes;
		if (refreshes > 0 && gap > max_gap)
			max_gap <= gap;
	end
endmodule : vrc_mem_model

// file: dv/testbench.sv
// Self-checking bench for the video memory random-port controller.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import vrc_pkg::*;
	localparam int REF = 40;
	logic clk = 0;
	logic rst_n = 0;
	logic req_valid = 0;
	logic req_last = 0;
	logic [1:0] req_cmd = '0;
	logic [ADDR_W-1:0] req_row = '0;
	logic [ADDR_W-1:0] req_col = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic [DATA_W-1:0] req_mask = '0;
	logic req_ready, rd_valid, row_strobe_n, column_strobe_n, write_enable_n;
	logic transfer_select_n, serial_mode_select_n, random_data_pins_oe;
	logic [DATA_W-1:0] rd_data, random_data_pins_o, dq, dq_out;
	logic [ADDR_W-1:0] multiplexed_address;
	int err_total = 0;
	int checks = 0;
	int faults, refreshes, max_gap;
	int seed = 32'h8e00;
	logic [DATA_W-1:0] shadow [int];

	always #5 clk = ~clk;
	// Pin level from both parties
	assign dq = random_data_pins_oe ? random_data_pins_o : dq_out;

	vrc_ctrl #(.REFRESH_ROW_CYCLES(REF)) i_vrc_ctrl (.clk, .rst_n, .req_valid, .req_ready,
		.req_cmd, .req_row, .req_col, .req_last, .req_wdata, .req_mask, .rd_valid, .rd_data,
		.row_strobe_n, .column_strobe_n, .write_enable_n, .transfer_select_n,
		.serial_mode_select_n, .multiplexed_address, .random_data_pins_o,
		.random_data_pins_oe, .random_data_pins_i(dq));
	vrc_mem_model i_vrc_mem_model (.clk, .row_strobe_n, .column_strobe_n, .write_enable_n,
		.transfer_select_n, .multiplexed_address, .random_data_pins_oe, .dq, .dq_out,
		.faults, .refreshes, .max_gap);

	task automatic tally_and_finish;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	task automatic cmp4(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp4

	task automatic cmp1(string what, logic exp, logic got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp1

	function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] old, wd, mk);
		return (old & ~mk) | (wd & mk);
	endfunction : merge

	// One request held until taken; reads waited on, writes shadowed
	task automatic access(logic [1:0] cmd, logic [ADDR_W-1:0] row, col,
		logic [DATA_W-1:0] wd, mk, logic last);
		int n;
		int a;
		n = 0;
		a = {row, col};
		@(posedge clk);
		req_valid <= 1'b1;
		req_cmd <= cmd;
		req_row <= row;
		req_col <= col;
		req_wdata <= wd;
		req_mask <= mk;
		req_last <= last;
		do @(posedge clk); while (req_ready !== 1'b1 && ++n < 300);
		req_valid <= 1'b0;
		cmp1("request taken", 1'b1, req_ready);
		if (cmd == CMD_READ) begin
			n = 0;
			do @(posedge clk); while (rd_valid !== 1'b1 && ++n < 40);
			cmp1("read valid", 1'b1, rd_valid);
			cmp4("read data", shadow[a], rd_data);
		end else
			shadow[a] = merge(shadow.exists(a) ? shadow[a] : 4'h0, wd,
				cmd == CMD_MASKED_WRITE ? mk : 4'hf);
	endtask : access

	// Watchdog, far beyond the expected run
	initial begin
		#400us;
		err_total++;
		$display("[FAIL] run expected done seen hang");
		tally_and_finish;
	end

	initial begin
		int r;
		int n0;
		logic open_r;
		logic last;
		logic [1:0] cmd;
		logic [ADDR_W-1:0] row, col;
		open_r = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// Corner cell, every command, masks with mixed and no bits
		access(CMD_WRITE, 9'h1ff, 9'h1ff, 4'ha, 4'h0, 1);
		access(CMD_READ, 9'h1ff, 9'h1ff, 4'h0, 4'h0, 1);
		access(CMD_MASKED_WRITE, 9'h1ff, 9'h1ff, 4'h5, 4'h6, 1);
		access(CMD_READ, 9'h1ff, 9'h1ff, 4'h0, 4'h0, 1);
		access(CMD_RMW, 9'h1ff, 9'h1ff, 4'h3, 4'h0, 1);
		access(CMD_MASKED_WRITE, 9'h1ff, 9'h1ff, 4'hf, 4'h0, 1);
		access(CMD_READ, 9'h1ff, 9'h1ff, 4'h0, 4'h0, 1);
		// Page of writes then reads in one row; the row closes between reads
		for (int c = 0; c < 16; c++)
			access(c < 8 ? CMD_WRITE : CMD_READ, 9'h0, 9'(c % 8), 4'(c ^ 9), 4'h0, c % 8 == 7);
		// Idle span: only refresh runs
		n0 = refreshes;
		repeat (20 * REF) @(posedge clk);
		cmp1("refresh count", 1'b1, (refreshes - n0) inside {[19:21]});
		repeat (300) begin
			r = $random(seed);
			row = {7'h0, r[1:0]};
			col = r[10:2];
			cmd = r[13:12];
			last = r[22];
			if (!shadow.exists({row, col}))
				cmd = CMD_WRITE;
			if (cmd == CMD_MASKED_WRITE && open_r)
				cmd = CMD_RMW;
			if (cmd == CMD_MASKED_WRITE)
				last = 1'b1;
			access(cmd, row, col, r[17:14], r[21:18], last);
			open_r = !last;
		end
		cmp1("refresh spacing", 1'b1, max_gap <= 2 * REF);
		cmp1("pin faults", 1'b1, faults == 0);
		cmp1("serial select", 1'b1, serial_mode_select_n);
		tally_and_finish;
	end
endmodule : testbench
